// ===== ccdr_top.sv
// How it works
// - Status output is low while measuring, high between measurements.
// - Digits scan from top digit down to bottom digit with matching BCD.
// - BCD data changes before the digit drive rises, lagging 2 to 6 us.
// - Each digit is a plain 8-4-2-1 binary code.
// - Leading zero blanking touches segments only, never the BCD outputs.
// - Decimal point position follows mode and range; none for external range.
// - Overflow lights the decimal point in the top digit slot.
// - Rising edges on both A and B return the input logic to unprimed.
// - Single-cycle range measures exactly one primed event, then completes.
// - Repetitive alternating inputs prime automatically.
// - After B falls, a 200 ms update runs before any new measurement.
// - Scan rate is timebase over 2e4, or over 2e3 in 1 MHz mode.
// - Idle time is 2e6 ticks, or 2e5 ticks in 1 MHz mode.
// - Nominal refresh is 500 Hz with 244 us digit drive time.
// - A 6 us gap blanks all digit and segment drives between slots.
// - Zeros left of the decimal point are blanked up to the first nonzero.
// - Overflow disables leading zero blanking.
// - In 1 MHz mode, period and time interval shift the point right.
// - Display test shows eights with points unless display off blanks all digit and segment drives; BCD keeps scanning.
//
// Chosen here: the address map and the Avalon-MM slave port.
module ccdr_top #(
  parameter int IDLE_TICKS_10M = ccdr_pkg::IDLE_TICKS_10M,
  parameter int IDLE_TICKS_1M = ccdr_pkg::IDLE_TICKS_1M
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_input_a,
  input wire logic i_input_b,
  input wire logic i_gate_done,
  input wire logic [31:0] i_count_bcd,
  input wire logic i_overflow,
  output logic o_count_enable,
  output logic o_meas_status,
  output logic o_store_b,
  output logic o_counter_reset,
  output logic [3:0] o_bcd,
  output logic [7:0] o_digit,
  output logic [6:0] o_seg,
  output logic o_seg_dp,
  output logic o_buffered_timebase_out
);

  function automatic logic [3:0] digit_of(input logic [31:0] value, input logic [2:0] idx);
    digit_of = value[{idx, 2'b00} +: 4];
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction

  function automatic logic [3:0] dp_digit(input logic [2:0] mode, input logic [2:0] range,
                                          input logic sel_1mhz);
    logic [3:0] r;
    r = {1'b0, range};
    if (range >= ccdr_pkg::RANGE_EXT) begin
      dp_digit = 4'h0;
    end else if (mode == ccdr_pkg::MODE_RATIO) begin
      dp_digit = r + 4'h1;
    end else if (mode == ccdr_pkg::MODE_UNIT) begin
      dp_digit = 4'h1;
    end else if (sel_1mhz && (mode == ccdr_pkg::MODE_PERIOD || mode == ccdr_pkg::MODE_TINT)) begin
      dp_digit = r + 4'h1;
    end else begin
      dp_digit = r + 4'h2;
    end
  endfunction

  function automatic logic [9:0] ti_target(input logic [2:0] range);
    case (range)
      3'h0: ti_target = ccdr_pkg::TI_EVENTS_R0;
      3'h1: ti_target = ccdr_pkg::TI_EVENTS_R1;
      3'h2: ti_target = ccdr_pkg::TI_EVENTS_R2;
      default: ti_target = ccdr_pkg::TI_EVENTS_R3;
    endcase
  endfunction

  logic [8:0] ctrl;
  logic ack;
  logic [7:0] tb_cnt;
  logic tick;
  ccdr_pkg::ccdr_seq_t seq;
  ccdr_pkg::ccdr_seq_t next_seq;
  ccdr_pkg::ccdr_ti_t ti;
  ccdr_pkg::ccdr_ti_t next_ti;
  logic [20:0] idle_cnt;
  logic [9:0] ti_events;
  logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  logic a_rose_seen, b_rose_seen;
  logic [31:0] disp;
  logic ovf;
  logic [2:0] idx;
  logic drive_on;
  logic [7:0] blank_digit;
  logic run_zero;

  wire [2:0] mode = ctrl[ccdr_pkg::CTRL_MODE_LSB +: 3];
  wire [2:0] range = ctrl[ccdr_pkg::CTRL_RANGE_LSB +: 3];
  wire sel_1mhz = ctrl[ccdr_pkg::CTRL_SEL_1MHZ_BIT];
  wire disp_test = ctrl[ccdr_pkg::CTRL_TEST_BIT];
  wire disp_off = ctrl[ccdr_pkg::CTRL_OFF_BIT];

  // Avalon slave: one wait state, write commits on the accepting edge.
  wire req = i_avs_read | i_avs_write;
  wire wr_ctrl = i_avs_write & ack & (i_avs_address == ccdr_pkg::ADDR_CTRL);
  wire [31:0] status_word = {25'h000_0000, idx, ovf, ti, seq == ccdr_pkg::SEQ_IDLE};
  wire [31:0] rd_mux = (i_avs_address == ccdr_pkg::ADDR_CTRL) ? {23'h00_0000, ctrl} :
                       (i_avs_address == ccdr_pkg::ADDR_STATUS) ? status_word :
                       (i_avs_address == ccdr_pkg::ADDR_VALUE) ? disp : 32'h0000_0000;
  assign o_avs_waitrequest = req & ~ack;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
      ctrl <= ccdr_pkg::CTRL_RESET;
    end else begin
      ack <= req & ~ack;
      if (i_avs_read && !ack) begin
        o_avs_readdata <= rd_mux;
      end
      if (wr_ctrl && i_avs_byteenable[0]) begin
        ctrl[7:0] <= i_avs_writedata[7:0];
      end
      if (wr_ctrl && i_avs_byteenable[1]) begin
        ctrl[8] <= i_avs_writedata[8];
      end
    end
  end

  // Timebase tick divider and buffered timebase output.
  wire [7:0] tb_div = sel_1mhz ? ccdr_pkg::CLK_PER_TB_1M : ccdr_pkg::CLK_PER_TB_10M;
  wire tb_last = tb_cnt >= tb_div - 8'h01;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tb_cnt <= 8'h00;
      tick <= 1'b0;
      o_buffered_timebase_out <= 1'b0;
    end else begin
      tb_cnt <= tb_last ? 8'h00 : tb_cnt + 8'h01;
      tick <= tb_last;
      o_buffered_timebase_out <= tb_cnt < {1'b0, tb_div[7:1]};
    end
  end

  // Pin synchronisers and edge detection.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {a_s1, a_s2, a_s3} <= 3'h7;
      {b_s1, b_s2, b_s3} <= 3'h7;
    end else begin
      {a_s1, a_s2, a_s3} <= {i_input_a, a_s1, a_s2};
      {b_s1, b_s2, b_s3} <= {i_input_b, b_s1, b_s2};
    end
  end

  wire a_fall = a_s3 & ~a_s2;
  wire b_fall = b_s3 & ~b_s2;
  wire a_rise = ~a_s3 & a_s2;
  wire b_rise = ~b_s3 & b_s2;
  wire both_rose = (a_rose_seen | a_rise) & (b_rose_seen | b_rise);

  // Time-interval priming and event counting.
  wire ti_active = (mode == ccdr_pkg::MODE_TINT) && (seq == ccdr_pkg::SEQ_RUN);
  wire ti_last = ti_events + 10'h001 >= ti_target(range);
  wire ti_end = ti_active && ti == ccdr_pkg::TI_TIMING && b_fall && ti_last;

  always_comb begin
    next_ti = ti;
    if (both_rose) begin
      next_ti = ccdr_pkg::TI_UNPRIMED;
    end else if (ti_active) begin
      unique case (ti)
        ccdr_pkg::TI_UNPRIMED: if (a_fall) next_ti = ccdr_pkg::TI_A_LOW;
        ccdr_pkg::TI_A_LOW: if (b_fall) next_ti = ccdr_pkg::TI_PRIMED;
        ccdr_pkg::TI_PRIMED: if (a_fall) next_ti = ccdr_pkg::TI_TIMING;
        ccdr_pkg::TI_TIMING: begin
          if (b_fall) begin
            next_ti = (range == 3'h0) ? ccdr_pkg::TI_UNPRIMED : ccdr_pkg::TI_PRIMED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ti <= ccdr_pkg::TI_UNPRIMED;
      ti_events <= 10'h000;
      a_rose_seen <= 1'b0;
      b_rose_seen <= 1'b0;
    end else begin
      ti <= next_ti;
      a_rose_seen <= both_rose ? 1'b0 : (a_rose_seen | a_rise) & ~a_fall;
      b_rose_seen <= both_rose ? 1'b0 : (b_rose_seen | b_rise) & ~b_fall;
      if (seq == ccdr_pkg::SEQ_IDLE) begin
        ti_events <= 10'h000;
      end else if (ti_active && ti == ccdr_pkg::TI_TIMING && b_fall) begin
        ti_events <= ti_events + 10'h001;
      end
    end
  end

  // Measurement sequencer with the idle interval between measurements.
  wire ti_ranged = (mode == ccdr_pkg::MODE_TINT) && (range != ccdr_pkg::RANGE_EXT);
  wire meas_end = ti_ranged ? ti_end : i_gate_done;
  wire [20:0] idle_ticks = sel_1mhz ? 21'(IDLE_TICKS_1M) : 21'(IDLE_TICKS_10M);
  wire idle_last = tick && idle_cnt >= idle_ticks - 21'h0_0001;
  wire at_store = seq == ccdr_pkg::SEQ_IDLE && idle_cnt == ccdr_pkg::STORE_AT_TICK;
  wire at_reset = seq == ccdr_pkg::SEQ_IDLE && idle_cnt == ccdr_pkg::RESET_AT_TICK;

  always_comb begin
    next_seq = seq;
    unique case (seq)
      ccdr_pkg::SEQ_RUN: if (meas_end) next_seq = ccdr_pkg::SEQ_IDLE;
      ccdr_pkg::SEQ_IDLE: if (idle_last) next_seq = ccdr_pkg::SEQ_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq <= ccdr_pkg::SEQ_RUN;
      idle_cnt <= 21'h0_0000;
      o_meas_status <= 1'b0;
      o_store_b <= 1'b1;
      o_counter_reset <= 1'b0;
      o_count_enable <= 1'b0;
      disp <= 32'h0000_0000;
      ovf <= 1'b0;
    end else begin
      seq <= next_seq;
      if (seq != ccdr_pkg::SEQ_IDLE) begin
        idle_cnt <= 21'h0_0000;
      end else if (tick) begin
        idle_cnt <= idle_cnt + 21'h0_0001;
      end
      o_meas_status <= next_seq == ccdr_pkg::SEQ_IDLE;
      o_store_b <= ~at_store;
      o_counter_reset <= at_reset;
      o_count_enable <= (mode == ccdr_pkg::MODE_TINT) ?
                        (next_seq == ccdr_pkg::SEQ_RUN && next_ti == ccdr_pkg::TI_TIMING) :
                        (next_seq == ccdr_pkg::SEQ_RUN);
      if (at_store && tick) begin
        disp <= i_count_bcd;
        ovf <= i_overflow;
      end
    end
  end

  // Digit scan and display drive.
  ccdr_scan u_scan (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick),
    .i_sel_1mhz(sel_1mhz),
    .o_idx(idx),
    .o_drive_on(drive_on)
  );

  wire [3:0] dp_pos = dp_digit(mode, range, sel_1mhz);
  wire [3:0] dp_eff = (dp_pos == 4'h0) ? 4'h1 : dp_pos;

  always_comb begin
    run_zero = 1'b1;
    blank_digit = 8'h00;
    for (int d = 7; d >= 0; d--) begin
      run_zero = run_zero & (digit_of(disp, 3'(d)) == 4'h0);
      blank_digit[d] = run_zero & (4'(d) >= dp_eff) & ~ovf;
    end
  end

  wire show = drive_on & ~disp_off;
  wire [3:0] cur = digit_of(disp, idx);
  wire [7:0] next_digit = show ? (8'h01 << idx) : 8'h00;
  wire [6:0] next_seg = !show ? 7'h00 :
                        disp_test ? 7'h7f :
                        blank_digit[idx] ? 7'h00 : seg7(cur);
  wire next_dp = show & (disp_test | (idx == 3'h7 & ovf) | ({1'b0, idx} + 4'h1 == dp_pos));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bcd <= 4'h0;
      o_digit <= 8'h00;
      o_seg <= 7'h00;
      o_seg_dp <= 1'b0;
    end else begin
      o_bcd <= cur;
      o_digit <= next_digit;
      o_seg <= next_seg;
      o_seg_dp <= next_dp;
    end
  end

endmodule

// ===== ccdr_pkg.sv
package ccdr_pkg;

  // Core clock and the two timebase rates it emulates.
  localparam int CLK_HZ = 250_000_000;
  localparam int TB_HZ_10M = 10_000_000;
  localparam int TB_HZ_1M = 1_000_000;
  localparam logic [7:0] CLK_PER_TB_10M = 8'(CLK_HZ / TB_HZ_10M);
  localparam logic [7:0] CLK_PER_TB_1M = 8'(CLK_HZ / TB_HZ_1M);

  // Scan timing, counted in timebase ticks.
  localparam int DIGITS = 8;
  localparam int SCAN_DIV_10M = 20_000;
  localparam int SCAN_DIV_1M = 2_000;
  localparam logic [11:0] SLOT_TICKS_10M = 12'(SCAN_DIV_10M / DIGITS);
  localparam logic [11:0] SLOT_TICKS_1M = 12'(SCAN_DIV_1M / DIGITS);
  localparam int T_BLANK_NS = 6000;
  localparam int T_LAG_NS = 4000;
  localparam logic [11:0] BLANK_TICKS_10M = 12'(T_BLANK_NS * (TB_HZ_10M / 1_000_000) / 1000);
  localparam logic [11:0] BLANK_TICKS_1M = 12'(T_BLANK_NS * (TB_HZ_1M / 1_000_000) / 1000);
  localparam logic [11:0] LAG_TICKS_10M = 12'(T_LAG_NS * (TB_HZ_10M / 1_000_000) / 1000);
  localparam logic [11:0] LAG_TICKS_1M = 12'(T_LAG_NS * (TB_HZ_1M / 1_000_000) / 1000);

  // Interval between measurements, in timebase ticks.
  localparam int IDLE_TICKS_10M = 2_000_000;
  localparam int IDLE_TICKS_1M = 200_000;
  localparam logic [20:0] STORE_AT_TICK = 21'h0_0001;
  localparam logic [20:0] RESET_AT_TICK = 21'h0_0003;

  // Time-interval event counts per range.
  localparam logic [9:0] TI_EVENTS_R0 = 10'h001;
  localparam logic [9:0] TI_EVENTS_R1 = 10'h00a;
  localparam logic [9:0] TI_EVENTS_R2 = 10'h064;
  localparam logic [9:0] TI_EVENTS_R3 = 10'h3e8;

  // Register map, byte addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_VALUE = 4'h8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RANGE_LSB = 3;
  localparam int CTRL_SEL_1MHZ_BIT = 6;
  localparam int CTRL_TEST_BIT = 7;
  localparam int CTRL_OFF_BIT = 8;

  typedef enum logic [2:0] {
    MODE_FREQ = 3'h0,
    MODE_PERIOD = 3'h1,
    MODE_RATIO = 3'h2,
    MODE_TINT = 3'h3,
    MODE_UNIT = 3'h4,
    MODE_OSC = 3'h5
  } ccdr_mode_t;

  localparam logic [2:0] RANGE_EXT = 3'h4;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_IDLE = 2'b01
  } ccdr_seq_t;

  typedef enum logic [1:0] {
    TI_UNPRIMED = 2'b00,
    TI_A_LOW = 2'b01,
    TI_PRIMED = 2'b11,
    TI_TIMING = 2'b10
  } ccdr_ti_t;

endpackage

// ===== ccdr_scan.sv
// Digit slot sequencer: blanking gap, data step, then digit drive.
module ccdr_scan (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_tick,
  input wire logic i_sel_1mhz,
  output logic [2:0] o_idx,
  output logic o_drive_on
);

  logic [11:0] cnt;
  wire [11:0] slot_ticks = i_sel_1mhz ? ccdr_pkg::SLOT_TICKS_1M : ccdr_pkg::SLOT_TICKS_10M;
  wire [11:0] blank_ticks = i_sel_1mhz ? ccdr_pkg::BLANK_TICKS_1M : ccdr_pkg::BLANK_TICKS_10M;
  wire [11:0] lag_ticks = i_sel_1mhz ? ccdr_pkg::LAG_TICKS_1M : ccdr_pkg::LAG_TICKS_10M;
  wire last = cnt >= slot_ticks - 12'h001;
  wire [11:0] next_cnt = last ? 12'h000 : cnt + 12'h001;
  wire step = cnt == blank_ticks - lag_ticks;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 12'h000;
      o_idx <= 3'h0;
      o_drive_on <= 1'b0;
    end else if (i_tick) begin
      cnt <= next_cnt;
      if (step) begin
        o_idx <= o_idx - 3'h1;
      end
      o_drive_on <= next_cnt >= blank_ticks;
    end
  end

endmodule

// ===== ccdr_sva.sv
module ccdr_sva (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic o_count_enable,
  input wire logic o_meas_status,
  input wire logic o_store_b,
  input wire logic o_counter_reset,
  input wire logic [3:0] o_bcd,
  input wire logic [7:0] o_digit,
  input wire logic [6:0] o_seg,
  input wire logic o_seg_dp
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire logic req;
  wire logic drv;
  logic [3:0] bcd_q;
  logic [11:0] bcd_age;
  assign req = i_avs_read | i_avs_write;
  assign drv = |o_digit;
  // Counts clocks since the BCD value last changed.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bcd_q <= 4'h0;
      bcd_age <= 12'h000;
    end else begin
      bcd_q <= o_bcd;
      bcd_age <= (o_bcd != bcd_q) ? 12'h000 : bcd_age + {11'h000, ~&bcd_age};
    end
  end
  a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held past one wait state");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  a_digit_single: assert property ($onehot0(o_digit))
    else $error("more than one digit driven");
  a_seg_dark: assert property (!drv |-> (o_seg == 7'h00 && !o_seg_dp))
    else $error("segments lit with no digit");
  a_gap_hold: assert property ($fell(drv) |=> !drv [*8])
    else $error("blanking gap too short");
  a_bcd_hold: assert property (drv && $past(drv) |-> $stable(o_bcd))
    else $error("bcd changed during drive");
  a_bcd_lead: assert property ($rose(drv) |-> bcd_age >= 12'h1f4)
    else $error("bcd leads drive by too little");
  a_run_busy: assert property (o_count_enable |-> !o_meas_status)
    else $error("status high while counting");
  a_store_idle: assert property (!o_store_b |-> o_meas_status)
    else $error("store outside idle");
  a_store_width: assert property ($fell(o_store_b) |-> !o_store_b [*8])
    else $error("store pulse too short");
  a_clear_after: assert property ($fell(o_store_b) |-> ##[40:600] $rose(o_counter_reset))
    else $error("counter reset missing after store");
  a_store_soon: assert property ($rose(o_meas_status) |-> ##[1:600] $fell(o_store_b))
    else $error("store missing in idle");
endmodule

// ===== ccdr_led_model.sv
module ccdr_led_model (
  input wire logic [3:0] i_bcd,
  input wire logic [7:0] i_digit,
  output logic [31:0] o_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] digit_q;
  // Each digit's nibble is captured on the rising edge of its drive.
  initial begin
    o_value = 32'h0000_0000;
    digit_q = 8'h00;
    forever begin
      @(i_digit);
      for (int k = 0; k < 8; k++) begin
        if (i_digit[k] && !digit_q[k]) begin
          o_value[4*k +: 4] = i_bcd;
        end
      end
      digit_q = i_digit;
    end
  end
endmodule

// ===== ccdr_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, rst_b, rd, wr, a_in, b_in, gate, wreq, cnt_en, status, store_b, clr, dp, drv_on;
  logic tbo, ovf_in;
  logic [3:0] addr, bcd;
  logic [31:0] wdata, count, rdata, shown;
  logic [7:0] digit;
  logic [6:0] seg;
  int n_errors, n_checks;
  ccdr_top #(.IDLE_TICKS_10M(40), .IDLE_TICKS_1M(40)) uut (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_input_a(a_in), .i_input_b(b_in),
    .i_gate_done(gate), .i_count_bcd(count), .i_overflow(ovf_in), .o_count_enable(cnt_en),
    .o_meas_status(status), .o_store_b(store_b), .o_counter_reset(clr), .o_bcd(bcd),
    .o_digit(digit), .o_seg(seg), .o_seg_dp(dp), .o_buffered_timebase_out(tbo)
  );
  ccdr_led_model u_led (.i_bcd(bcd), .i_digit(digit), .o_value(shown));
  always #2 i_clk = ~i_clk;
  always_comb drv_on = |digit;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= lim) chk("wait", 32'h0, 32'h1);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    while (wreq !== 1'b0 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    q = rdata;
    if (n == 50) chk("bus", 32'h0, 32'h1);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic pin(input logic a, input logic b);
    a_in <= a;
    b_in <= b;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic t_measure();
    int m, k, j;
    chk("status reset", 32'(status), 32'h0);
    count <= 32'h0304_5678;
    gate <= 1'b1;
    @(posedge i_clk);
    gate <= 1'b0;
    wait_for(status, 1'b1, 8, m);
    wait_for(store_b, 1'b0, 100, m);
    chk("store in idle", 32'(status), 32'h1);
    wait_for(clr, 1'b1, 100, k);
    chk("clear after store", 32'(k), 32'h0000_0032);
    wait_for(status, 1'b0, 1200, j);
    chk("idle span", 32'(m + k + j > 970 && m + k + j <= 1000), 32'h1);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, ccdr_pkg::ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", q, 32'(ccdr_pkg::CTRL_RESET));
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'hffff_ff80, q);
    bus(1'b0, ccdr_pkg::ADDR_CTRL, 32'h0, q);
    chk("ctrl bits", q, 32'h0000_0180);
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'h0, q);
    bus(1'b1, ccdr_pkg::ADDR_VALUE, 32'h0, q);
    bus(1'b0, ccdr_pkg::ADDR_VALUE, 32'h0, q);
    chk("value", q, 32'h0304_5678);
    bus(1'b0, 4'hc, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_scan();
    int n;
    wait_for(drv_on, 1'b1, 3000, n);
    chk("top digit", 32'(digit), 32'h80);
    chk("top bcd", 32'(bcd), 32'h0);
    chk("top seg", 32'({dp, seg}), 32'h0);
    wait_for(drv_on, 1'b0, 70000, n);
    chk("drive time", 32'(n), 32'h0000_ee48);
    wait_for(drv_on, 1'b1, 3000, n);
    chk("gap", 32'(n), 32'h0000_05dc);
    chk("next digit", 32'(digit), 32'h40);
    chk("next bcd", 32'(bcd), 32'h3);
    chk("next seg", 32'({dp, seg}), 32'h4f);
    chk("latched", 32'(shown[31:24]), 32'h03);
  endtask
  task automatic t_tint();
    logic [31:0] q;
    int n;
    ovf_in <= 1'b1;
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'(ccdr_pkg::MODE_TINT), q);
    wait_for(status, 1'b0, 3000, n);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    bus(1'b0, ccdr_pkg::ADDR_STATUS, 32'h0, q);
    chk("primed", 32'(q[2:1]), 32'h3);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    chk("count on", 32'(cnt_en), 32'h1);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    chk("stopped", 32'(status), 32'h1);
    chk("count off", 32'(cnt_en), 32'h0);
    bus(1'b0, ccdr_pkg::ADDR_STATUS, 32'h0, q);
    chk("one event", 32'(q[2:1]), 32'h0);
    wait_for(status, 1'b0, 2000, n);
    chk("update", 32'(n > 950 && n < 1000), 32'h1);
    bus(1'b0, ccdr_pkg::ADDR_STATUS, 32'h0, q);
    chk("overflow latched", 32'(q[3]), 32'h1);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b1);
    bus(1'b0, ccdr_pkg::ADDR_STATUS, 32'h0, q);
    chk("unprimed", 32'(q[2:1]), 32'h0);
  endtask
  task automatic t_disp();
    logic [31:0] q;
    int n;
    wait_for(tbo, 1'b0, 30, n);
    wait_for(tbo, 1'b1, 30, n);
    wait_for(tbo, 1'b0, 30, n);
    chk("timebase high", 32'(n), 32'h0000_000c);
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'h0000_0080, q);
    @(posedge i_clk);
    chk("test seg", 32'({dp, seg}), 32'h0000_00ff);
    chk("test bcd", 32'(bcd), 32'h3);
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'h0000_0180, q);
    @(posedge i_clk);
    chk("off drives", 32'({digit, dp, seg}), 32'h0);
    chk("off bcd", 32'(bcd), 32'h3);
    repeat (10) @(posedge i_clk);
    bus(1'b1, ccdr_pkg::ADDR_CTRL, 32'h0, q);
    @(posedge i_clk);
    chk("back on", 32'(digit), 32'h40);
  endtask
  initial begin
    i_clk = 1'b0;
    rst_b = 1'b0;
    {rd, wr, gate, ovf_in} = 4'h0;
    {a_in, b_in} = 2'h3;
    addr = 4'h0;
    wdata = 32'h0;
    count = 32'h0;
    repeat (4) @(posedge i_clk);
    rst_b <= 1'b1;
    @(posedge i_clk);
    t_measure();
    t_regs();
    t_scan();
    t_tint();
    t_disp();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    n_errors++;
    test_done();
  end
endmodule
bind ccdr_top ccdr_sva u_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_count_enable(o_count_enable),
  .o_meas_status(o_meas_status), .o_store_b(o_store_b), .o_counter_reset(o_counter_reset),
  .o_bcd(o_bcd), .o_digit(o_digit), .o_seg(o_seg), .o_seg_dp(o_seg_dp)
);
